// *** src/wdt_top.sv ***
`timescale 1ns/100ps

// Overview of operation
// - Four count clocks picked by select field
// - Counter runs; missed service resets system
// - Timeout taken from timeout value pair
// - Enabled after reset; cleared enable stops it
// - Refresh keys within 16 clocks, else reset
// - Good refresh clears counter to zero
// - Prescale bit divides count clock by 256
// - Counter readable anytime; writes never load it
// - Unlock keys within 16 bus clocks
// - Reconfigure within 128 clocks after unlock
// - Halt, sleep, deep sleep suspend unless enabled
module wdt_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [wdt_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [wdt_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic low_power_1khz_source,
    input wire logic internal_32khz_reference,
    input wire logic external_oscillator_source,
    input wire logic halt_mode,
    input wire logic sleep_mode,
    input wire logic deep_sleep_mode,
    output logic system_reset_req
);
    import wdt_pkg::*;

    wdt_ctrl_t ctrl_q;
    logic [15:0] toval_q, win_q, cnt_q, key;
    logic [ADDR_W-1:0] waddr_q;
    logic [31:0] wdata_q, rd_word;
    logic [3:0] wstrb_q, stat;
    logic [7:0] lock_cnt_q;
    logic [4:0] gap_q, gap_d;
    wdt_seq_t seq_q, seq_d;
    logic unlocked_q, sw_unlock_q, active, timeout, rd_hit;
    logic lpo_tick, ref_tick, ext_tick, div_tick, src_tick, cnt_tick;
    logic wr_fire, wr_ctrl, wr_toval, wr_win, wr_cnt, wr_hit, key_wr;
    logic refresh_done, unlock_done, seq_fail, unlock_fail;

    // Byte-lane merge of a 16-bit field
    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [31:0] d,
        input logic [3:0] s
    );
        return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Count clock sources and prescaler

    // Pin clocks synchronised into aclk
    wdt_edge_sync u_lpo_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(low_power_1khz_source),
        .tick(lpo_tick)
    );
    wdt_edge_sync u_ref_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(internal_32khz_reference),
        .tick(ref_tick)
    );
    wdt_edge_sync u_ext_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(external_oscillator_source),
        .tick(ext_tick)
    );

    // Running only when enabled and not suspended by a low-power mode
    assign active = ctrl_q.enable
        && (ctrl_q.run_in_halt_select || !halt_mode)
        && (ctrl_q.run_in_sleep || !sleep_mode)
        && (ctrl_q.run_in_deep_sleep || !deep_sleep_mode);

    // Source select
    always_comb begin
        case (ctrl_q.clk_sel)
            CLK_BUS: src_tick = active;
            CLK_LPO: src_tick = active & lpo_tick;
            CLK_EXT: src_tick = active & ext_tick;
            default: src_tick = active & ref_tick;
        endcase
    end

    wdt_div256 u_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick_in(src_tick),
        .tick_out(div_tick)
    );

    // Optional divide by 256
    assign cnt_tick = ctrl_q.divide_by_256_select ? (div_tick & active) : src_tick;

    ////////////////////////////////////////////////////////////////////////////
    // Bus write side

    // Address and data are taken independently, then performed together
    assign wr_fire = !awready && !wready && !bvalid;

    // Write address channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            waddr_q <= '0;
        end else if (awvalid && awready) begin
            awready <= 1'b0;
            waddr_q <= awaddr;
        end else if (bvalid && bready) begin
            awready <= 1'b1;
        end
    end

    // Write data channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready <= 1'b1;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (wvalid && wready) begin
            wready <= 1'b0;
            wdata_q <= wdata;
            wstrb_q <= wstrb;
        end else if (bvalid && bready) begin
            wready <= 1'b1;
        end
    end

    // Write decode
    always_comb begin
        wr_ctrl = 1'b0;
        wr_toval = 1'b0;
        wr_win = 1'b0;
        wr_cnt = 1'b0;
        wr_hit = 1'b1;
        if (waddr_q == OFS_CTRL) begin
            wr_ctrl = wr_fire;
        end else if (waddr_q == OFS_TOVAL) begin
            wr_toval = wr_fire;
        end else if (waddr_q == OFS_WIN) begin
            wr_win = wr_fire;
        end else if (waddr_q == OFS_CNT) begin
            wr_cnt = wr_fire;
        end else if (waddr_q == OFS_STAT) begin
            wr_hit = 1'b1;
        end else begin
            wr_hit = 1'b0;
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration, writable only while unlocked

    // Control register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= CTRL_RST;
        end else if (wr_ctrl && unlocked_q && wstrb_q[0]) begin
            ctrl_q <= wdt_ctrl_t'(wdata_q[7:0]);
        end
    end

    // Timeout and window values
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            toval_q <= TOVAL_RST;
            win_q <= WIN_RST;
        end else if (unlocked_q) begin
            if (wr_toval) begin
                toval_q <= merge16(toval_q, wdata_q, wstrb_q);
            end
            if (wr_win) begin
                win_q <= merge16(win_q, wdata_q, wstrb_q);
            end
        end
    end

    // Unlock window; a control write closes it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            unlocked_q <= 1'b1;
            sw_unlock_q <= 1'b0;
            lock_cnt_q <= UNLOCK_LOAD;
        end else if (unlock_done) begin
            unlocked_q <= 1'b1;
            sw_unlock_q <= 1'b1;
            lock_cnt_q <= UNLOCK_LOAD;
        end else if (unlocked_q) begin
            if (wr_ctrl || lock_cnt_q == 8'h00) begin
                unlocked_q <= 1'b0;
                sw_unlock_q <= 1'b0;
            end else begin
                lock_cnt_q <= lock_cnt_q - 8'h01;
            end
        end
    end

    // Only a software unlock that runs out forces a reset
    assign unlock_fail = unlocked_q && sw_unlock_q && !wr_ctrl && (lock_cnt_q == 8'h00);

    ////////////////////////////////////////////////////////////////////////////
    // Key sequences on the counter pair

    // Keys need both low byte lanes
    assign key_wr = wr_cnt && (wstrb_q[1:0] == 2'h3);
    assign key = wdata_q[15:0];

    // Sequence decode
    always_comb begin
        seq_d = seq_q;
        gap_d = gap_q;
        refresh_done = 1'b0;
        unlock_done = 1'b0;
        seq_fail = 1'b0;
        case (seq_q)
            SEQ_IDLE: begin
                if (key_wr && key == KEY_REFRESH_1) begin
                    if (ctrl_q.window_en && cnt_q < win_q) begin
                        seq_fail = 1'b1;
                    end else begin
                        seq_d = SEQ_REFRESH;
                        gap_d = KEY_GAP_LOAD;
                    end
                end else if (key_wr && key == KEY_UNLOCK_1) begin
                    seq_d = SEQ_UNLOCK;
                    gap_d = KEY_GAP_LOAD;
                end
            end
            default: begin // Either sequence waiting for its second key
                if (key_wr) begin
                    seq_d = SEQ_IDLE;
                    refresh_done = (seq_q == SEQ_REFRESH) && (key == KEY_REFRESH_2);
                    unlock_done = (seq_q == SEQ_UNLOCK) && (key == KEY_UNLOCK_2);
                    seq_fail = !refresh_done && !unlock_done;
                end else if (gap_q == 5'h00) begin
                    seq_d = SEQ_IDLE;
                    seq_fail = 1'b1;
                end else begin
                    gap_d = gap_q - 5'h01;
                end
            end
        endcase
    end

    // Sequence state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seq_q <= SEQ_IDLE;
            gap_q <= '0;
        end else begin
            seq_q <= seq_d;
            gap_q <= gap_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counter and reset request

    // Counter, cleared only by a good refresh
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= CNT_CLEAR;
        end else if (refresh_done) begin
            cnt_q <= CNT_CLEAR;
        end else if (cnt_tick && cnt_q != toval_q) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    // Timeout when the count meets the programmed value
    assign timeout = active && (cnt_q == toval_q);

    // Sticky request, cleared by the system reset it causes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            system_reset_req <= 1'b0;
        end else if (timeout || seq_fail || unlock_fail) begin
            system_reset_req <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus read side

    // Status bits
    always_comb begin
        stat = '0;
        stat[STAT_ACTIVE] = active;
        stat[STAT_REFRESH_ARMED] = (seq_q == SEQ_REFRESH);
        stat[STAT_UNLOCK_ARMED] = (seq_q == SEQ_UNLOCK);
        stat[STAT_UNLOCKED] = unlocked_q;
    end

    // Read decode
    always_comb begin
        rd_hit = 1'b1;
        if (araddr == OFS_CTRL) begin
            rd_word = 32'(ctrl_q);
        end else if (araddr == OFS_TOVAL) begin
            rd_word = 32'(toval_q);
        end else if (araddr == OFS_WIN) begin
            rd_word = 32'(win_q);
        end else if (araddr == OFS_CNT) begin
            rd_word = 32'(cnt_q);
        end else if (araddr == OFS_STAT) begin
            rd_word = 32'(stat);
        end else begin
            rd_word = '0;
            rd_hit = 1'b0;
        end
    end

    // Read channel: data latched when the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_word;
            rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid && rready) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
        end
    end

endmodule

// *** src/wdt_pkg.sv ***
package wdt_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register map, byte addresses
    localparam int ADDR_W = 5;
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_TOVAL = 5'h04;
    localparam logic [4:0] OFS_WIN = 5'h08;
    localparam logic [4:0] OFS_CNT = 5'h0c;
    localparam logic [4:0] OFS_STAT = 5'h10;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // Service and unlock keys
    localparam logic [15:0] KEY_REFRESH_1 = 16'ha602;
    localparam logic [15:0] KEY_REFRESH_2 = 16'hb480;
    localparam logic [15:0] KEY_UNLOCK_1 = 16'hc520;
    localparam logic [15:0] KEY_UNLOCK_2 = 16'hd928;

    // Bus-clock deadlines
    localparam int KEY_GAP_CLKS = 16;
    localparam int UNLOCK_CLKS = 128;
    localparam logic [4:0] KEY_GAP_LOAD = 5'(KEY_GAP_CLKS - 1);
    localparam logic [7:0] UNLOCK_LOAD = 8'(UNLOCK_CLKS - 1);

    // Fixed prescaler
    localparam int PRESCALE_DIV = 256;
    localparam logic [7:0] PRESCALE_LAST = 8'(PRESCALE_DIV - 1);

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [15:0] TOVAL_RST = 16'hffff;
    localparam logic [15:0] WIN_RST = 16'h0000;
    localparam logic [15:0] CNT_CLEAR = 16'h0000;

    // Count clock choices
    typedef enum logic [1:0] {
        CLK_BUS,
        CLK_LPO,
        CLK_EXT,
        CLK_REF
    } wdt_clk_sel_t;

    // Control register layout, bit 0 upward is enable
    typedef struct packed {
        wdt_clk_sel_t clk_sel;
        logic run_in_deep_sleep;
        logic run_in_sleep;
        logic run_in_halt_select;
        logic divide_by_256_select;
        logic window_en;
        logic enable;
    } wdt_ctrl_t;

    localparam wdt_ctrl_t CTRL_RST = 8'h01;

    // Status register bit positions
    localparam int STAT_ACTIVE = 0;
    localparam int STAT_REFRESH_ARMED = 1;
    localparam int STAT_UNLOCK_ARMED = 2;
    localparam int STAT_UNLOCKED = 3;

    // Key sequence states
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_REFRESH,
        SEQ_UNLOCK
    } wdt_seq_t;

endpackage

// *** src/wdt_edge_sync.sv ***
`timescale 1ns/100ps

// Brings a slow clock pin into aclk and marks each rising edge
module wdt_edge_sync (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pin,
    output logic tick
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    // Two-stage synchroniser, then one stage for the edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
            tick <= 1'b0;
        end else begin
            meta_q <= pin;
            sync_q <= meta_q;
            last_q <= sync_q;
            tick <= sync_q & ~last_q;
        end
    end
endmodule

// *** src/wdt_div256.sv ***
`timescale 1ns/100ps

// Passes one tick out of every PRESCALE_DIV ticks in
module wdt_div256 (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tick_in,
    output logic tick_out
);
    import wdt_pkg::*;

    logic [7:0] div_q;

    // Divider count and output tick
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_q <= '0;
            tick_out <= 1'b0;
        end else begin
            tick_out <= tick_in && (div_q == PRESCALE_LAST);
            if (tick_in) begin
                div_q <= div_q + 8'h01;
            end
        end
    end
endmodule

// *** tb/wdt_props.sv ***
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Port-level checks on bus handshakes and watchdog reset causes
module wdt_props
    import wdt_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [4:0] awaddr,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [4:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic system_reset_req
);
    logic bv_q;
    logic [4:0] a_q;
    logic [31:0] d_q;
    logic [3:0] s_q;
    logic [1:0] kind_q;
    logic [3:0] gap_q;
    logic ul_q;
    logic [7:0] ul_n_q;
    logic perf;
    logic key;

    // Write takes effect as bvalid rises
    assign perf = bvalid && !bv_q;
    assign key = perf && a_q == OFS_CNT && s_q[1:0] == 2'b11;

    // Capture of the accepted write
    always_ff @(posedge aclk) begin
        bv_q <= aresetn && bvalid;
        if (awvalid && awready) a_q <= awaddr;
        if (wvalid && wready) begin
            d_q <= wdata;
            s_q <= wstrb;
        end
    end

    // First-key tracking with gap count
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            kind_q <= 2'h0;
            gap_q <= 4'h0;
        end else if (key) begin
            kind_q <= kind_q != 2'h0 ? 2'h0 : d_q[15:0] == KEY_REFRESH_1 ? 2'h1 :
                      d_q[15:0] == KEY_UNLOCK_1 ? 2'h2 : 2'h0;
            gap_q <= 4'h0;
        end else if (kind_q != 2'h0 && gap_q != 4'hf) gap_q <= gap_q + 4'h1;
    end

    // Software unlock window tracking
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ul_q <= 1'b0;
            ul_n_q <= 8'h00;
        end else if (key && kind_q == 2'h2 && d_q[15:0] == KEY_UNLOCK_2) begin
            ul_q <= 1'b1;
            ul_n_q <= 8'h00;
        end else if (perf && a_q == OFS_CTRL && s_q[0]) ul_q <= 1'b0;
        else if (ul_q && ul_n_q != 8'h7f) ul_n_q <= ul_n_q + 8'h01;
    end

    a_req_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        system_reset_req |=> system_reset_req) else $error("reset request dropped");
    a_gap_expiry: assert property (@(posedge aclk) disable iff (!aresetn)
        kind_q != 2'h0 && gap_q == 4'hf && !key |-> ##[0:2] system_reset_req)
        else $error("late second key gave no reset");
    a_wrong_key: assert property (@(posedge aclk) disable iff (!aresetn)
        key && (kind_q == 2'h1 && d_q[15:0] != KEY_REFRESH_2 ||
        kind_q == 2'h2 && d_q[15:0] != KEY_UNLOCK_2) |-> ##[0:2] system_reset_req)
        else $error("wrong second key gave no reset");
    a_unlock_expiry: assert property (@(posedge aclk) disable iff (!aresetn)
        ul_q && ul_n_q == 8'h7f |-> ##[0:3] system_reset_req)
        else $error("unlock window expired without reset");
    a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        awvalid && awready && wvalid && wready |-> ##2 bvalid) else $error("no write response");
    a_write_busy: assert property (@(posedge aclk) disable iff (!aresetn)
        bvalid |-> !awready && !wready) else $error("write taken while busy");
    a_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write response moved");
    a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        arvalid && arready |=> rvalid && !arready) else $error("no read response");
    a_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read data moved");
    a_read_unmapped: assert property (@(posedge aclk) disable iff (!aresetn)
        arvalid && arready && araddr > OFS_STAT |=>
        rresp == RESP_SLVERR && rdata == 32'h0000_0000) else $error("unmapped read not refused");
endmodule

bind wdt_top wdt_props u_props (.*);

// *** tb/wdt_top_test.sv ***
`timescale 1ns/100ps

module wdt_top_test;
    import wdt_pkg::*;
    localparam logic [31:0] ONE = 32'h0000_0001;
    localparam logic [31:0] ZERO = 32'h0000_0000;
    logic aclk = 0;
    logic aresetn = 0;
    logic [4:0] awaddr = 0;
    logic [4:0] araddr = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 0;
    logic [3:0] wstrb = 0;
    logic [2:0] pin = 0;
    logic [2:0] mode = 0;
    logic awready, wready, bvalid, arready, rvalid, system_reset_req;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, v, w2;
    int num_errors = 0, check_count = 0, pc = 0, n;
    int per[4] = '{1, 20, 14, 26};

    ////////////////////////////////////////////////////////////////////////////
    // Clock and slow source pins of distinct rates
    always #25 aclk = ~aclk;
    always @(posedge aclk) begin
        pc <= pc + 1;
        if (pc % 10 == 0) pin[0] <= ~pin[0];
        if (pc % 7 == 0) pin[1] <= ~pin[1];
        if (pc % 13 == 0) pin[2] <= ~pin[2];
    end

    wdt_top uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .low_power_1khz_source(pin[0]), .external_oscillator_source(pin[1]),
        .internal_32khz_reference(pin[2]), .halt_mode(mode[0]), .sleep_mode(mode[1]),
        .deep_sleep_mode(mode[2]), .system_reset_req(system_reset_req));

    ////////////////////////////////////////////////////////////////////////////
    // Compare helpers
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task chkr(input string nm, input int lo, input int hi, input logic [31:0] g);
        check_count++;
        if ($isunknown(g) || g < lo || g > hi) begin
            num_errors++;
            $display("Error %s expected %0d to %0d seen %0d", nm, lo, hi, g);
        end
    endtask

    // Bus master cycles
    task wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 0;
    endtask

    task rd(input logic [4:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 0;
        end while (rvalid !== 1'b1);
        v = rdata;
        r = rresp;
        rready <= 0;
    endtask

    // Sequences built from bus cycles
    task nap(input int c);
        repeat (c) @(posedge aclk);
    endtask

    task rst();
        aresetn <= 0;
        nap(20);
        aresetn <= 1;
    endtask

    task ul();
        wr(OFS_CNT, {16'h0000, KEY_UNLOCK_1});
        wr(OFS_CNT, {16'h0000, KEY_UNLOCK_2});
    endtask

    task rf();
        wr(OFS_CNT, {16'h0000, KEY_REFRESH_1});
        wr(OFS_CNT, {16'h0000, KEY_REFRESH_2});
    endtask

    task span(input int c);
        rd(OFS_CNT);
        w2 = v;
        nap(c);
        rd(OFS_CNT);
        v = v - w2;
    endtask

    task summarize();
        $display("Checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Hang guard
    initial begin
        #(50 * 20000);
        num_errors++;
        $display("Error run expected done seen hang");
        summarize();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Test sequence
    initial begin
        rst();
        wr(OFS_TOVAL, 32'h0000_0100);
        chk("toval_bresp", RESP_OKAY, r);
        rd(OFS_TOVAL);
        chk("toval", 32'h0000_0100, v);
        chk("toval_rresp", RESP_OKAY, r);
        rd(OFS_CTRL);
        chk("ctrl_reset", ONE, v);
        rd(5'h14);
        chk("unmapped_rresp", RESP_SLVERR, r);
        wr(5'h14, ZERO);
        chk("unmapped_bresp", RESP_SLVERR, r);
        rf();
        rd(OFS_CNT);
        chkr("cnt_cleared", 0, 8, v);
        wr(OFS_CNT, 32'h0000_1234);
        rd(OFS_CNT);
        chkr("cnt_no_load", 0, 20, v);
        span(30);
        chkr("cnt_runs", 31, 35, v);
        rf();
        n = 0;
        while (system_reset_req !== 1'b1 && n < 400) begin
            @(posedge aclk);
            n++;
        end
        chkr("timeout", 250, 260, n);
        rst();
        wr(OFS_CNT, {16'h0000, KEY_REFRESH_1});
        rd(OFS_STAT);
        chk("stat_armed", 32'h0000_000b, v);
        nap(8);
        chk("gap_early", ZERO, system_reset_req);
        nap(10);
        chk("gap_late", ONE, system_reset_req);
        rst();
        wr(OFS_CNT, {16'h0000, KEY_REFRESH_1});
        wr(OFS_CNT, 32'h0000_1111);
        nap(3);
        chk("wrong_key", ONE, system_reset_req);
        rst();
        nap(140);
        chk("boot_window", ZERO, system_reset_req);
        wr(OFS_TOVAL, 32'h0000_0005);
        rd(OFS_TOVAL);
        chk("locked", 32'h0000_ffff, v);
        ul();
        nap(140);
        chk("unlock_expiry", ONE, system_reset_req);
        rst();
        nap(140);
        for (int i = 0; i < 3; i++) begin
            ul();
            wr(OFS_CTRL, ONE);
            mode <= 3'(1 << i);
            span(20);
            chk("suspended", ZERO, v);
            ul();
            wr(OFS_CTRL, ONE | (32'h0000_0008 << i));
            span(20);
            chkr("mode_runs", 21, 25, v);
            mode <= 0;
        end
        for (int s = 1; s < 4; s++) begin
            ul();
            wr(OFS_CTRL, ONE | (s << 6));
            span(200);
            chkr("source", 203 / per[s] - 1, 203 / per[s] + 1, v);
        end
        ul();
        wr(OFS_CTRL, 32'h0000_0005);
        span(600);
        chkr("prescale", 2, 3, v);
        ul();
        wr(OFS_CTRL, ZERO);
        span(30);
        chk("disabled", ZERO, v);
        rst();
        nap(140);
        ul();
        wr(OFS_WIN, 32'h0000_0100);
        wr(OFS_CTRL, 32'h0000_0003);
        nap(150);
        rf();
        rd(OFS_CNT);
        chkr("window_refresh", 0, 8, v);
        chk("window_no_reset", ZERO, system_reset_req);
        rf();
        nap(2);
        chk("early_refresh", ONE, system_reset_req);
        summarize();
    end
endmodule
